// File: rtl/ccd_pkg.sv
// Shared constants and types for the crank cut detector.
package ccd_pkg;
   localparam int          CLK_PERIOD_NS   = 100;
   localparam int          SEC_TICK_MS     = 1000;
   localparam int          TICK_CYCLES     = SEC_TICK_MS * 1000000 / CLK_PERIOD_NS;
   localparam int          MEAS_W          = 16;
   localparam int          SEC_W           = 8;
   localparam logic [7:0]  CRANK_MAX_S     = 8'h0F;
   localparam logic [7:0]  OIL_DELAY_DEF_S = 8'h02;
   localparam int          NUM_CAUSE       = 6;
   localparam int          NUM_MEAS        = 4;
   localparam int          CAUSE_TIMER     = 0;
   localparam int          CAUSE_VOLT      = 1;
   localparam int          CAUSE_FREQ      = 2;
   localparam int          CAUSE_RPM       = 3;
   localparam int          CAUSE_CHARGE    = 4;
   localparam int          CAUSE_OIL       = 5;
   localparam logic        OIL_SW_RST      = 1'b1;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CRANK,
      ST_HOLD
   } ccd_state_e;
endpackage

// File: rtl/ccd_thresh.sv
// Enabled greater-or-equal threshold compare.
`timescale 1ns/10ps
module ccd_thresh #(
   parameter int W = ccd_pkg::MEAS_W
) (
   input  wire logic         en,
   input  wire logic [W-1:0] value,
   input  wire logic [W-1:0] limit,
   output      logic         reached
);
   assign reached = en && (value >= limit);
endmodule // ccd_thresh

// File: rtl/ccd_timer.sv
// Whole-second timer with a clock prescaler.
`timescale 1ns/10ps
module ccd_timer #(
   parameter int TICK_CYCLES = ccd_pkg::TICK_CYCLES
) (
   input  wire logic  clk,
   input  wire logic  rst_b,
   ccd_timer_if.timer t
);
   logic [31:0] pre;

   // Counting stops at the limit so the seconds field can never wrap.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pre    <= 32'h0;
         t.secs <= 8'h00;
      end else if (t.clear) begin
         pre    <= 32'h0;
         t.secs <= 8'h00;
      end else if (t.run && !t.expired) begin
         if (pre == 32'(TICK_CYCLES - 1)) begin
            pre    <= 32'h0;
            t.secs <= t.secs + 8'h01;
         end else begin
            pre <= pre + 32'h1;
         end
      end
   end

   assign t.expired = (t.secs >= t.limit);
endmodule // ccd_timer

// File: rtl/ccd_timer_if.sv
// Control and status of one seconds timer.
`timescale 1ns/10ps
interface ccd_timer_if;
   logic                     clear;
   logic                     run;
   logic [ccd_pkg::SEC_W-1:0] limit;
   logic [ccd_pkg::SEC_W-1:0] secs;
   logic                     expired;

   modport owner (output clear, output run, output limit, input secs, input expired);
   modport timer (input clear, input run, input limit, output secs, output expired);
endinterface

// File: rtl/ccd_top.sv
// Crank termination logic: starter output and its cut conditions.
`timescale 1ns/10ps
module ccd_top #(
   parameter int W           = ccd_pkg::MEAS_W,
   parameter int TICK_CYCLES = ccd_pkg::TICK_CYCLES
) (
   input  wire logic                          clk,
   input  wire logic                          rst_b,
   input  wire logic                          crank_req,
   input  wire logic [W-1:0]                  l1_volt,
   input  wire logic [W-1:0]                  l1_freq,
   input  wire logic [W-1:0]                  eng_rpm,
   input  wire logic [W-1:0]                  chg_volt,
   input  wire logic [W-1:0]                  oil_press,
   input  wire logic                          oil_low_sw,
   input  wire logic [W-1:0]                  cut_volt_thr,
   input  wire logic [W-1:0]                  cut_freq_thr,
   input  wire logic [W-1:0]                  cut_rpm_thr,
   input  wire logic [W-1:0]                  cut_chg_thr,
   input  wire logic [W-1:0]                  oil_press_thr,
   input  wire logic [ccd_pkg::SEC_W-1:0]     crank_time_s,
   input  wire logic                          charge_connected,
   input  wire logic                          oil_cut_en,
   input  wire logic                          oil_sw_priority,
   input  wire logic                          oil_delay_load,
   input  wire logic [ccd_pkg::SEC_W-1:0]     oil_delay_s,
   output      logic                          crank_out,
   output      logic                          attempt_done,
   output      logic [ccd_pkg::NUM_CAUSE-1:0] cut_cause,
   output      logic [ccd_pkg::SEC_W-1:0]     oil_delay
);
   ccd_timer_if      crank_tmr ();
   ccd_timer_if      oil_tmr ();

   ccd_pkg::ccd_state_e state;
   ccd_pkg::ccd_state_e next_state;

   logic                          sw_meta;
   logic                          sw_low;
   logic                          sender_ok;
   logic                          oil_det;
   logic [ccd_pkg::NUM_CAUSE-1:0] cond;
   logic                          cut_any;
   logic [ccd_pkg::NUM_MEAS-1:0]  meas_en;
   logic [ccd_pkg::NUM_MEAS-1:0]  meas_hit;
   logic [W-1:0]                  meas_val [ccd_pkg::NUM_MEAS];
   logic [W-1:0]                  meas_thr [ccd_pkg::NUM_MEAS];

   // The switch is a field pin and passes two flip-flops; it resets to the low pressure state.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sw_meta <= ccd_pkg::OIL_SW_RST;
         sw_low  <= ccd_pkg::OIL_SW_RST;
      end else begin
         sw_meta <= oil_low_sw;
         sw_low  <= sw_meta;
      end
   end

   assign meas_val[0] = l1_volt;
   assign meas_val[1] = l1_freq;
   assign meas_val[2] = eng_rpm;
   assign meas_val[3] = chg_volt;
   assign meas_thr[0] = cut_volt_thr;
   assign meas_thr[1] = cut_freq_thr;
   assign meas_thr[2] = cut_rpm_thr;
   assign meas_thr[3] = cut_chg_thr;
   assign meas_en     = {charge_connected, 3'h7};

   for (genvar i = 0; i < ccd_pkg::NUM_MEAS; i++) begin : g_meas
      ccd_thresh #(.W(W)) u_thr (
         .en      (meas_en[i]),
         .value   (meas_val[i]),
         .limit   (meas_thr[i]),
         .reached (meas_hit[i])
      );
   end

   ccd_thresh #(.W(W)) u_sender (
      .en      (!oil_sw_priority),
      .value   (oil_press),
      .limit   (oil_press_thr),
      .reached (sender_ok)
   );

   // A closed low pressure switch means no pressure, so pressure is its inverse.
   assign oil_det = oil_cut_en && (!sw_low || sender_ok);

   // Oil delay setting holds its default until loaded.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         oil_delay <= ccd_pkg::OIL_DELAY_DEF_S;
      end else if (oil_delay_load) begin
         oil_delay <= oil_delay_s;
      end
   end

   // Crank timer is held cleared outside an attempt, so each attempt starts from zero.
   assign crank_tmr.clear = (state != ccd_pkg::ST_CRANK);
   assign crank_tmr.run   = (state == ccd_pkg::ST_CRANK);
   assign crank_tmr.limit = (crank_time_s > ccd_pkg::CRANK_MAX_S) ? ccd_pkg::CRANK_MAX_S : crank_time_s;

   // The delay restarts whenever pressure is lost, so a flickering switch cannot add up.
   assign oil_tmr.clear = (state != ccd_pkg::ST_CRANK) || !oil_det;
   assign oil_tmr.run   = (state == ccd_pkg::ST_CRANK) && oil_det;
   assign oil_tmr.limit = oil_delay;

   ccd_timer #(.TICK_CYCLES(TICK_CYCLES)) u_crank_tmr (
      .clk   (clk),
      .rst_b (rst_b),
      .t     (crank_tmr.timer)
   );

   ccd_timer #(.TICK_CYCLES(TICK_CYCLES)) u_oil_tmr (
      .clk   (clk),
      .rst_b (rst_b),
      .t     (oil_tmr.timer)
   );

   // One bit per cause; the cause record and the OR below both read this vector.
   always_comb begin
      cond                       = '0;
      cond[ccd_pkg::CAUSE_TIMER] = crank_tmr.expired;
      cond[ccd_pkg::CAUSE_VOLT]  = meas_hit[0];
      cond[ccd_pkg::CAUSE_FREQ]  = meas_hit[1];
      cond[ccd_pkg::CAUSE_RPM]   = meas_hit[2];
      cond[ccd_pkg::CAUSE_CHARGE] = meas_hit[3];
      cond[ccd_pkg::CAUSE_OIL]   = oil_det && oil_tmr.expired;
   end

   assign cut_any = |cond;

   // A cut parks the machine in hold until the request goes away, so the starter cannot re-engage by itself.
   always_comb begin
      next_state = state;
      case (state)
         ccd_pkg::ST_IDLE: begin
            if (crank_req) begin
               next_state = ccd_pkg::ST_CRANK;
            end
         end
         ccd_pkg::ST_CRANK: begin
            if (!crank_req) begin
               next_state = ccd_pkg::ST_IDLE;
            end else if (cut_any) begin
               next_state = ccd_pkg::ST_HOLD;
            end
         end
         ccd_pkg::ST_HOLD: begin
            if (!crank_req) begin
               next_state = ccd_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = ccd_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= ccd_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Outputs follow the next state so the starter drops on the same edge the cut is seen.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         crank_out    <= 1'b0;
         attempt_done <= 1'b0;
      end else begin
         crank_out    <= (next_state == ccd_pkg::ST_CRANK);
         attempt_done <= (next_state == ccd_pkg::ST_HOLD);
      end
   end

   // Every condition true at the cut edge is recorded; a new attempt clears the record.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cut_cause <= '0;
      end else if (state == ccd_pkg::ST_IDLE && crank_req) begin
         cut_cause <= '0;
      end else if (state == ccd_pkg::ST_CRANK && crank_req && cut_any) begin
         cut_cause <= cond;
      end
   end

   // Helper: length of the current crank pulse in clock cycles.
   logic [39:0] crank_cyc;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         crank_cyc <= 40'h0;
      end else if (crank_out) begin
         crank_cyc <= crank_cyc + 40'h1;
      end else begin
         crank_cyc <= 40'h0;
      end
   end

   // Every enabled cut condition drops the starter at the next edge and keeps it off.
   chk_or_cut: assert property (@(posedge clk) disable iff (!rst_b)
      (state == ccd_pkg::ST_CRANK && crank_req && cut_any) |=> !crank_out && attempt_done)
      else $error("Crank not released on a cut condition.");

   chk_hold_off: assert property (@(posedge clk) disable iff (!rst_b)
      (state == ccd_pkg::ST_HOLD && crank_req) |=> !crank_out && attempt_done)
      else $error("Starter driven again before the request was released.");

   chk_abort_drop: assert property (@(posedge clk) disable iff (!rst_b)
      (state == ccd_pkg::ST_CRANK && !crank_req) |=> !crank_out && !attempt_done)
      else $error("Starter not dropped when the request was withdrawn.");

   chk_timer_cap: assert property (@(posedge clk) disable iff (!rst_b)
      crank_cyc <= 40'(TICK_CYCLES) * 40'(ccd_pkg::CRANK_MAX_S) + 40'h2)
      else $error("Crank lasted beyond the fifteen second cap.");

   // Voltage, frequency and speed at or above their thresholds each end the crank by itself; charge also needs charge_connected.
   chk_volt_cut: assert property (@(posedge clk) disable iff (!rst_b)
      (crank_out && state == ccd_pkg::ST_CRANK && l1_volt >= cut_volt_thr) |=> !crank_out)
      else $error("Voltage threshold did not cut the crank.");

   chk_freq_cut: assert property (@(posedge clk) disable iff (!rst_b)
      (crank_out && state == ccd_pkg::ST_CRANK && l1_freq >= cut_freq_thr) |=> !crank_out)
      else $error("Frequency threshold did not cut the crank.");

   chk_rpm_cut: assert property (@(posedge clk) disable iff (!rst_b)
      (crank_out && state == ccd_pkg::ST_CRANK && eng_rpm >= cut_rpm_thr) |=> !crank_out)
      else $error("Speed threshold did not cut the crank.");

   chk_charge_gate: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(cut_cause[ccd_pkg::CAUSE_CHARGE]) |->
         $past(charge_connected) && ($past(chg_volt) >= $past(cut_chg_thr)))
      else $error("Charge cause set without enable or threshold.");

   // Oil pressure cuts only when enabled, and only once its delay has run out.
   chk_oil_enable: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(cut_cause[ccd_pkg::CAUSE_OIL]) |-> $past(oil_cut_en))
      else $error("Oil cause set while oil cut disabled.");

   chk_oil_delay: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(cut_cause[ccd_pkg::CAUSE_OIL]) |->
         $past(oil_det) && ($past(oil_tmr.secs) >= $past(oil_delay)))
      else $error("Oil cut before its delay elapsed.");

   chk_oil_default: assert property (@(posedge clk)
      $rose(rst_b) |-> oil_delay == ccd_pkg::OIL_DELAY_DEF_S)
      else $error("Oil delay not at its default after reset.");

   chk_delay_load: assert property (@(posedge clk) disable iff (!rst_b)
      oil_delay_load |=> oil_delay == $past(oil_delay_s))
      else $error("Oil delay setting not taken from the load strobe.");

   // The switch is judged at the pin two edges back, so a broken synchroniser cannot hide behind it.
   chk_switch_used: assert property (@(posedge clk) disable iff (!rst_b)
      (oil_cut_en && $past(rst_b, 2) && $past(rst_b) && !$past(oil_low_sw, 2)) |-> oil_det)
      else $error("Oil switch pressure ignored.");

   chk_sender_gate: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(cut_cause[ccd_pkg::CAUSE_OIL]) |->
         !$past(sw_low) || (!$past(oil_sw_priority) && ($past(oil_press) >= $past(oil_press_thr))))
      else $error("Oil cut without switch pressure or an allowed sender reading.");

   chk_timer_restart: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(crank_out) |-> crank_tmr.secs == 8'h00)
      else $error("Crank timer not restarted at attempt start.");

   chk_cause_clear: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(crank_out) |-> cut_cause == '0)
      else $error("Cause record not cleared at attempt start.");

   // Main scenarios: timeout, a measured cut, a delayed oil cut, a charge cut and an abort.
   cov_timeout: cover property (@(posedge clk) disable iff (!rst_b)
      $rose(cut_cause[ccd_pkg::CAUSE_TIMER]));

   cov_volt: cover property (@(posedge clk) disable iff (!rst_b)
      $rose(cut_cause[ccd_pkg::CAUSE_VOLT]));

   cov_oil: cover property (@(posedge clk) disable iff (!rst_b)
      $rose(cut_cause[ccd_pkg::CAUSE_OIL]));

   cov_charge: cover property (@(posedge clk) disable iff (!rst_b)
      $rose(cut_cause[ccd_pkg::CAUSE_CHARGE]));

   cov_abort: cover property (@(posedge clk) disable iff (!rst_b)
      crank_out ##1 (!crank_out && !attempt_done));
endmodule // ccd_top

// File: verification/ccd_engine_model.sv
// Behavioural engine: the starter spins it up while fires is set, and the oil switch opens once it turns fast enough.
`timescale 1ns/10ps
module ccd_engine_model (
   input  wire logic                       clk,
   input  wire logic                       rst_b,
   input  wire logic                       crank_out,
   input  wire logic                       fires,
   output      logic [ccd_pkg::MEAS_W-1:0] eng_rpm,
   output      logic                       oil_low_sw
);
   // An engine that does not fire stays at zero speed, so its oil switch stays closed and cannot end its attempt.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         eng_rpm <= 16'h0000;
      end else if (!fires) begin
         eng_rpm <= 16'h0000;
      end else if (crank_out && eng_rpm < 16'hFF00) begin
         eng_rpm <= eng_rpm + 16'h0040;
      end
   end

   // The switch reports low pressure until the engine speed reaches 16'h0100, as a real pressure switch does.
   assign oil_low_sw = (eng_rpm < 16'h0100);
endmodule // ccd_engine_model

// File: verification/crank_cut_detector_tb.sv
// Self-checking bench for the crank cut detector.
`timescale 1ns/10ps
module crank_cut_detector_tb;
   typedef struct {
      logic [15:0] volt, freq, chg, oilp, rpm_thr;
      logic        conn, oen, prio, fires;
      logic [7:0]  cs;
      logic [5:0]  cause;
      int          lo, hi;
   } ccd_row_s;

   logic        clk = 1'b0, rst_b = 1'b0, crank_req = 1'b0, fires = 1'b0;
   logic [15:0] l1_volt = '0, l1_freq = '0, chg_volt = '0, oil_press = '0, cut_rpm_thr = 16'hFFFF;
   logic [15:0] cut_chg_thr = 16'h0018, oil_press_thr = 16'h0064;
   logic        charge_connected = 1'b0, oil_cut_en = 1'b0, oil_sw_priority = 1'b0, oil_delay_load = 1'b0;
   logic [7:0]  crank_time_s = 8'h03, oil_delay_s = 8'h00;
   logic [15:0] eng_rpm;
   logic        oil_low_sw, crank_out, attempt_done;
   logic [5:0]  cut_cause;
   logic [7:0]  oil_delay;
   int          failures = 0, comparisons = 0;
   ccd_row_s    rows[12];

   always #50 clk = ~clk;

   ccd_top #(.W(16), .TICK_CYCLES(10)) ccd_top_i (
      .clk(clk), .rst_b(rst_b), .crank_req(crank_req), .l1_volt(l1_volt), .l1_freq(l1_freq),
      .eng_rpm(eng_rpm), .chg_volt(chg_volt), .oil_press(oil_press), .oil_low_sw(oil_low_sw),
      .cut_volt_thr(16'h00C8), .cut_freq_thr(16'h0032), .cut_rpm_thr(cut_rpm_thr), .cut_chg_thr(cut_chg_thr),
      .oil_press_thr(oil_press_thr), .crank_time_s(crank_time_s), .charge_connected(charge_connected),
      .oil_cut_en(oil_cut_en), .oil_sw_priority(oil_sw_priority), .oil_delay_load(oil_delay_load),
      .oil_delay_s(oil_delay_s), .crank_out(crank_out), .attempt_done(attempt_done),
      .cut_cause(cut_cause), .oil_delay(oil_delay));

   ccd_engine_model ccd_engine_model_i (
      .clk(clk), .rst_b(rst_b), .crank_out(crank_out), .fires(fires), .eng_rpm(eng_rpm), .oil_low_sw(oil_low_sw));

   task automatic test_done();
      $display("checks %0d, mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One whole attempt: raise the request, time the starter pulse, then confirm it stays off until release.
   task automatic attempt(input ccd_row_s r, input int idx);
      int n;
      int k;
      n = 0;
      l1_volt = r.volt; l1_freq = r.freq; chg_volt = r.chg; oil_press = r.oilp; cut_rpm_thr = r.rpm_thr;
      charge_connected = r.conn; oil_cut_en = r.oen; oil_sw_priority = r.prio; fires = r.fires;
      crank_time_s = r.cs;
      @(negedge clk);
      crank_req = 1'b1;
      for (k = 0; k < 400; k++) begin
         @(negedge clk);
         if (crank_out === 1'b1) n++;
         else if (n > 0) break;
      end
      if (k == 400) begin
         failures++;
         $display("CHECK FAILED crank end expected by 400 seen none");
         test_done();
      end
      comparisons++;
      if (n < r.lo || n > r.hi) begin
         failures++;
         $display("CHECK FAILED crank length expected %0d..%0d seen %0d", r.lo, r.hi, n);
      end
      chk("cut_cause", {10'h000, r.cause}, {10'h000, cut_cause});
      @(negedge clk);
      chk("crank_out held off", 16'h0000, {15'h0000, crank_out});
      chk("attempt_done", 16'h0001, {15'h0000, attempt_done});
      crank_req = 1'b0;
      fires = 1'b0;
      repeat (2) @(negedge clk);
      chk("attempt_done cleared", 16'h0000, {15'h0000, attempt_done});
      $display("test row %0d done", idx);
   endtask

   initial begin
      rows[0]  = '{16'h00C7, 16'h0031, 16'h0017, 16'h0063, 16'hFFFF, 1, 1, 0, 0, 8'h03, 6'h01, 29, 33};
      rows[1]  = '{16'h00C8, 16'h0000, 16'h0000, 16'h0000, 16'hFFFF, 0, 0, 0, 0, 8'h0F, 6'h02, 1, 1};
      rows[2]  = '{16'h0000, 16'h0032, 16'h0000, 16'h0000, 16'hFFFF, 0, 0, 0, 0, 8'h0F, 6'h04, 1, 1};
      rows[3]  = '{16'h0000, 16'h0000, 16'h0018, 16'h0000, 16'hFFFF, 1, 0, 0, 0, 8'h0F, 6'h10, 1, 1};
      rows[4]  = '{16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF, 0, 0, 0, 0, 8'h01, 6'h01, 9, 13};
      rows[5]  = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0190, 0, 0, 0, 1, 8'h0F, 6'h08, 5, 10};
      rows[6]  = '{16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'hFFFF, 0, 1, 0, 0, 8'h0F, 6'h20, 19, 23};
      rows[7]  = '{16'h0000, 16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF, 0, 0, 0, 0, 8'h02, 6'h01, 19, 23};
      rows[8]  = '{16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'hFFFF, 0, 1, 1, 0, 8'h02, 6'h01, 19, 23};
      rows[9]  = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hFFFF, 0, 1, 1, 1, 8'h0F, 6'h20, 24, 32};
      rows[10] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hFFFF, 0, 0, 0, 0, 8'h14, 6'h01, 149, 153};
      rows[11] = '{16'h00C8, 16'h0032, 16'h0000, 16'h0000, 16'hFFFF, 0, 0, 0, 0, 8'h0F, 6'h06, 1, 1};
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      chk("oil_delay after reset", 16'h0002, {8'h00, oil_delay});
      chk("crank_out after reset", 16'h0000, {15'h0000, crank_out});
      foreach (rows[i]) attempt(rows[i], i);
      // A zero oil delay must cut at the first crank cycle once pressure is seen.
      oil_delay_s = 8'h00;
      oil_delay_load = 1'b1;
      @(negedge clk);
      oil_delay_load = 1'b0;
      chk("oil_delay loaded", 16'h0000, {8'h00, oil_delay});
      rows[6].lo = 1;
      rows[6].hi = 1;
      attempt(rows[6], 20);
      // Abort mid-crank: the next attempt must get the whole crank time again.
      crank_time_s = 8'h03;
      oil_cut_en = 1'b0;
      crank_req = 1'b1;
      repeat (15) @(negedge clk);
      crank_req = 1'b0;
      @(negedge clk);
      chk("crank_out after abort", 16'h0000, {15'h0000, crank_out});
      chk("cut_cause after abort", 16'h0000, {10'h000, cut_cause});
      attempt(rows[0], 21);
      // A reset in the middle of an attempt drops the starter and restores the oil delay default.
      crank_req = 1'b1;
      repeat (5) @(negedge clk);
      rst_b = 1'b0;
      crank_req = 1'b0;
      #1;
      chk("crank_out in reset", 16'h0000, {15'h0000, crank_out});
      chk("oil_delay in reset", 16'h0002, {8'h00, oil_delay});
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      attempt(rows[1], 22);
      // Lower thresholds turn the oil and charge near misses of the first row into cuts.
      oil_press_thr = 16'h0063;
      rows[0].cause = 6'h20;
      rows[0].lo = 19;
      rows[0].hi = 23;
      attempt(rows[0], 23);
      cut_chg_thr = 16'h0017;
      rows[0].cause = 6'h10;
      rows[0].lo = 1;
      rows[0].hi = 1;
      attempt(rows[0], 24);
      test_done();
   end
endmodule // crank_cut_detector_tb
